// [rtl/cas_pkg.sv]
package cas_pkg;

  // ----------------------------------------------------------------
  // operations and operand modes
  // ----------------------------------------------------------------
  // logic left shift is the same operation as arith_left_shift_op
  typedef enum logic [3:0] {
    none_op,
    add_carry_op,
    add_op,
    and_op,
    arith_left_shift_op,
    arith_right_shift_op,
    stack_ptr_imm_add_op,
    index_pair_imm_add_op,
    branch_carry_clear_op
  } cas_op_t;

  typedef enum logic [3:0] {
    inherent_mode,
    immediate_mode,
    direct_mode,
    extended_mode,
    indexed_off16_mode,
    indexed_off8_mode,
    indexed_no_offset_mode,
    indexed_post_inc_mode,
    indexed_off8_post_inc_mode,
    stack_off16_mode,
    stack_off8_mode,
    relative_mode
  } cas_mode_t;

  typedef enum logic [2:0] {
    st_opcode,
    st_prefix,
    st_operand,
    st_read,
    st_write,
    st_pad
  } cas_state_t;

  typedef struct packed {
    cas_op_t op;
    cas_mode_t mode;
    logic [2:0] need;
    logic [1:0] nbytes;
    logic to_index;
    logic legal;
  } cas_dec_t;

  // ----------------------------------------------------------------
  // condition code bit positions
  // ----------------------------------------------------------------
  localparam int CCR_V = 7;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;

  // ----------------------------------------------------------------
  // opcode map
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_PREFIX = 8'h9E;
  localparam logic [7:0] OPC_STACK_ADD = 8'hA7;
  localparam logic [7:0] OPC_INDEX_ADD = 8'hAF;
  localparam logic [7:0] OPC_BRANCH_CC = 8'h24;
  localparam logic [3:0] COL_SHL = 4'h8;
  localparam logic [3:0] COL_SHR = 4'h7;
  localparam logic [3:0] ROW_SH_DIR = 4'h3;
  localparam logic [3:0] ROW_SH_ACC = 4'h4;
  localparam logic [3:0] ROW_SH_IDX = 4'h5;
  localparam logic [3:0] ROW_SH_IX1 = 4'h6;
  localparam logic [3:0] ROW_SH_IX = 4'h7;
  localparam logic [3:0] ROW_SH_SP1 = 4'h6;
  localparam logic [3:0] COL_ADC = 4'h9;
  localparam logic [3:0] COL_ADD = 4'hB;
  localparam logic [3:0] COL_AND = 4'h4;
  localparam logic [3:0] ROW_IMM = 4'hA;
  localparam logic [3:0] ROW_DIR = 4'hB;
  localparam logic [3:0] ROW_EXT = 4'hC;
  localparam logic [3:0] ROW_IX2 = 4'hD;
  localparam logic [3:0] ROW_IX1 = 4'hE;
  localparam logic [3:0] ROW_IX = 4'hF;
  localparam logic [3:0] ROW_SP2 = 4'hD;
  localparam logic [3:0] ROW_SP1 = 4'hE;

  // ----------------------------------------------------------------
  // bus cycle counts
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_AR_IMM = 3'h2;
  localparam logic [2:0] CYC_AR_DIR = 3'h3;
  localparam logic [2:0] CYC_AR_EXT = 3'h4;
  localparam logic [2:0] CYC_AR_IX2 = 3'h4;
  localparam logic [2:0] CYC_AR_IX1 = 3'h3;
  localparam logic [2:0] CYC_AR_IX = 3'h3;
  localparam logic [2:0] CYC_AR_SP2 = 3'h5;
  localparam logic [2:0] CYC_AR_SP1 = 3'h4;
  localparam logic [2:0] CYC_SH_DIR = 3'h5;
  localparam logic [2:0] CYC_SH_INH = 3'h1;
  localparam logic [2:0] CYC_SH_IX1 = 3'h5;
  localparam logic [2:0] CYC_SH_IX = 3'h4;
  localparam logic [2:0] CYC_SH_SP1 = 3'h6;
  localparam logic [2:0] CYC_IMM_ADD = 3'h2;
  localparam logic [2:0] CYC_BRANCH = 3'h3;
  localparam logic [2:0] CYC_FIRST = 3'h1;

  // ----------------------------------------------------------------
  // values after reset, and the direct page high byte
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] HX_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [7:0] CCR_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;

endpackage

// [rtl/cas_alu.sv]
`timescale 1ns/1ps
module cas_alu (
  input cas_pkg::cas_op_t i_op,
  input logic [7:0] i_a,
  input logic [7:0] i_m,
  input logic [7:0] i_ccr,
  output logic [7:0] o_res,
  output logic [7:0] o_ccr
);
  import cas_pkg::*;

  // ----------------------------------------------------------------
  // result and flags
  // ----------------------------------------------------------------
  // purely combinational; the core registers whatever it commits
  always_comb begin
    logic [8:0] sum;
    logic [4:0] half;
    logic cin;
    sum = 9'h000;
    half = 5'h00;
    cin = (i_op == add_carry_op) ? i_ccr[CCR_C] : 1'b0;
    o_res = i_a;
    o_ccr = i_ccr; // interrupt mask is never touched here
    case (i_op)
      add_carry_op, add_op: begin
        sum = {1'b0, i_a} + {1'b0, i_m} + {8'h00, cin};
        half = {1'b0, i_a[3:0]} + {1'b0, i_m[3:0]} + {4'h0, cin};
        o_res = sum[7:0];
        o_ccr[CCR_C] = sum[8];
        o_ccr[CCR_H] = half[4];
        o_ccr[CCR_V] = (i_a[7] == i_m[7]) && (sum[7] != i_a[7]);
      end
      and_op: begin
        o_res = i_a & i_m;
        o_ccr[CCR_V] = 1'b0;
      end
      arith_left_shift_op: begin
        o_res = {i_a[6:0], 1'b0};
        o_ccr[CCR_C] = i_a[7];
        o_ccr[CCR_V] = i_a[6] ^ i_a[7]; // overflow is new sign xor carry
      end
      arith_right_shift_op: begin
        o_res = {i_a[7], i_a[7:1]};
        o_ccr[CCR_C] = i_a[0];
        o_ccr[CCR_V] = i_a[7] ^ i_a[0];
      end
      default: begin
      end
    endcase
    // sign and zero follow the 8-bit result
    if (i_op inside {add_carry_op, add_op, and_op, arith_left_shift_op,
                     arith_right_shift_op}) begin
      o_ccr[CCR_N] = o_res[7];
      o_ccr[CCR_Z] = (o_res == 8'h00);
    end
  end

endmodule

// [rtl/cas_core.sv]
// What this block does
// - add with carry: A gets A plus operand plus carry; V H N Z C updated.
// - add without carry: A gets A plus operand; V H N Z C updated.
// - stack pointer add: sign-extended immediate added, flags kept, 2 cycles.
// - index pair add: sign-extended immediate added, flags kept, 2 cycles.
// - AND: A gets A and operand; V cleared; N Z updated; H I C kept.
// - arithmetic ops: eight operand modes, each with its fixed cycle count.
// - left shift: operand shifted left into carry; V N Z C updated.
// - left shift counts: direct 5, register 1, off8 5, no offset 4, stack 6.
// - right shift: V N Z C updated, same opcodes layout and cycle counts.
// - branch on carry clear: signed offset taken if C is 0; 3 cycles.
// - relative mode: signed 8-bit offset from the stream forms the target.
// - off8 indexed: address is index pair plus unsigned 8-bit offset.
// - off16 indexed: address is index pair plus 16-bit offset.
// - post-increment no-offset indexing is never offered to these operations.
// - post-increment off8 indexing is never offered to these operations.
// - stack modes: address is stack pointer plus 8- or 16-bit offset.
// - flags: V bit 7, H bit 4, I bit 3, N bit 2, Z bit 1, C bit 0.
// - direct mode: operand gives low address byte, high byte is zero.
`timescale 1ns/1ps
module cas_core (
  input logic i_ref_clk,
  input logic i_rst,
  input logic i_ce,
  input logic i_fq_valid,
  input logic [7:0] i_fq_byte,
  output logic o_fq_ready,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  input logic [7:0] i_mem_rdata,
  output logic [7:0] o_acc,
  output logic [15:0] o_hx,
  output logic [15:0] o_sp,
  output logic [15:0] o_pc,
  output logic [7:0] o_ccr,
  output logic o_done,
  output logic o_illegal,
  output logic o_branch
);
  import cas_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sext8(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  // post-increment modes are left out of every row: no operation here uses them
  function automatic cas_dec_t decode(input logic [7:0] opc, input logic pre);
    cas_dec_t d;
    d = '{op: none_op, mode: inherent_mode, need: CYC_FIRST, nbytes: 2'h0,
          to_index: 1'b0, legal: 1'b1};
    if (!pre && opc == OPC_STACK_ADD) begin
      d.op = stack_ptr_imm_add_op;
      d.mode = immediate_mode;
      d.need = CYC_IMM_ADD;
      d.nbytes = 2'h1;
    end else if (!pre && opc == OPC_INDEX_ADD) begin
      d.op = index_pair_imm_add_op;
      d.mode = immediate_mode;
      d.need = CYC_IMM_ADD;
      d.nbytes = 2'h1;
    end else if (!pre && opc == OPC_BRANCH_CC) begin
      d.op = branch_carry_clear_op;
      d.mode = relative_mode;
      d.need = CYC_BRANCH;
      d.nbytes = 2'h1;
    end else if (opc[3:0] == COL_SHL || opc[3:0] == COL_SHR) begin
      d.op = (opc[3:0] == COL_SHL) ? arith_left_shift_op : arith_right_shift_op;
      d.nbytes = 2'h1;
      if (pre) begin
        d.mode = stack_off8_mode;
        d.need = CYC_SH_SP1;
        d.legal = (opc[7:4] == ROW_SH_SP1);
      end else begin
        case (opc[7:4])
          ROW_SH_DIR: {d.mode, d.need} = {direct_mode, CYC_SH_DIR};
          ROW_SH_ACC: {d.mode, d.need, d.nbytes} = {inherent_mode, CYC_SH_INH, 2'h0};
          ROW_SH_IDX: {d.mode, d.need, d.nbytes, d.to_index} =
                      {inherent_mode, CYC_SH_INH, 2'h0, 1'b1};
          ROW_SH_IX1: {d.mode, d.need} = {indexed_off8_mode, CYC_SH_IX1};
          ROW_SH_IX: {d.mode, d.need, d.nbytes} = {indexed_no_offset_mode, CYC_SH_IX, 2'h0};
          default: d.legal = 1'b0;
        endcase
      end
    end else if (opc[3:0] == COL_ADC || opc[3:0] == COL_ADD || opc[3:0] == COL_AND) begin
      d.op = (opc[3:0] == COL_ADC) ? add_carry_op :
             (opc[3:0] == COL_ADD) ? add_op : and_op;
      d.nbytes = 2'h1;
      if (pre) begin
        case (opc[7:4])
          ROW_SP2: {d.mode, d.need, d.nbytes} = {stack_off16_mode, CYC_AR_SP2, 2'h2};
          ROW_SP1: {d.mode, d.need} = {stack_off8_mode, CYC_AR_SP1};
          default: d.legal = 1'b0;
        endcase
      end else begin
        case (opc[7:4])
          ROW_IMM: {d.mode, d.need} = {immediate_mode, CYC_AR_IMM};
          ROW_DIR: {d.mode, d.need} = {direct_mode, CYC_AR_DIR};
          ROW_EXT: {d.mode, d.need, d.nbytes} = {extended_mode, CYC_AR_EXT, 2'h2};
          ROW_IX2: {d.mode, d.need, d.nbytes} = {indexed_off16_mode, CYC_AR_IX2, 2'h2};
          ROW_IX1: {d.mode, d.need} = {indexed_off8_mode, CYC_AR_IX1};
          ROW_IX: {d.mode, d.need, d.nbytes} = {indexed_no_offset_mode, CYC_AR_IX, 2'h0};
          default: d.legal = 1'b0;
        endcase
      end
    end else begin
      d.legal = 1'b0;
    end
    if (!d.legal) begin
      d.op = none_op;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cas_state_t state_reg, state_next;
  cas_op_t op_reg, op_next;
  cas_mode_t mode_reg, mode_next;
  logic [2:0] need_reg, need_next, cyc_reg, cyc_next;
  logic [1:0] left_reg, left_next;
  logic to_index_reg, to_index_next;
  logic [7:0] hi_reg, hi_next, acc_reg, acc_next, ccr_reg, ccr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [15:0] hx_reg, hx_next, sp_reg, sp_next, pc_reg, pc_next;
  logic [15:0] addr_reg, addr_next;
  logic req_reg, req_next, we_reg, we_next;
  logic done_reg, done_next, illegal_reg, illegal_next, branch_reg, branch_next;

  cas_dec_t dec;
  cas_op_t alu_op;
  logic [7:0] alu_a, alu_m, alu_res, alu_ccr;
  logic fetching, take, tgt_x, is_shift, fin, done_now;
  logic [2:0] fin_need;
  logic [15:0] off16, ea;

  assign fetching = (state_reg == st_opcode) || (state_reg == st_prefix) ||
                    (state_reg == st_operand);
  assign take = fetching && i_fq_valid;
  assign o_fq_ready = i_ce && fetching;
  assign dec = decode(i_fq_byte, state_reg == st_prefix);

  // ----------------------------------------------------------------
  // operand steering into the alu
  // ----------------------------------------------------------------
  assign alu_op = (state_reg == st_opcode) ? dec.op : op_reg;
  assign tgt_x = (state_reg == st_opcode) ? dec.to_index : to_index_reg;
  assign is_shift = (alu_op == arith_left_shift_op) || (alu_op == arith_right_shift_op);
  assign alu_a = (state_reg == st_read && is_shift) ? i_mem_rdata :
                 (tgt_x ? hx_reg[7:0] : acc_reg);
  assign alu_m = (state_reg == st_read) ? i_mem_rdata : i_fq_byte;

  cas_alu u_alu (
    .i_op(alu_op),
    .i_a(alu_a),
    .i_m(alu_m),
    .i_ccr(ccr_reg),
    .o_res(alu_res),
    .o_ccr(alu_ccr)
  );

  // effective address, formed as the last operand byte arrives
  always_comb begin
    off16 = {hi_reg, i_fq_byte};
    case (mode_reg)
      direct_mode: ea = {DIRECT_PAGE, i_fq_byte};
      extended_mode: ea = off16;
      indexed_off16_mode: ea = hx_reg + off16;
      indexed_off8_mode: ea = hx_reg + {8'h00, i_fq_byte};
      stack_off16_mode: ea = sp_reg + off16;
      stack_off8_mode: ea = sp_reg + {8'h00, i_fq_byte};
      default: ea = hx_reg;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer and architectural registers
  // ----------------------------------------------------------------
  // the cycle counter pads short work paths so every instruction spends
  // exactly its listed bus cycles; fetch stalls are not counted
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    mode_next = mode_reg;
    need_next = need_reg;
    cyc_next = cyc_reg;
    left_next = left_reg;
    to_index_next = to_index_reg;
    hi_next = hi_reg;
    acc_next = acc_reg;
    ccr_next = ccr_reg;
    wdata_next = wdata_reg;
    hx_next = hx_reg;
    sp_next = sp_reg;
    pc_next = take ? pc_reg + 16'h0001 : pc_reg;
    addr_next = addr_reg;
    req_next = 1'b0;
    we_next = 1'b0;
    done_next = 1'b0;
    illegal_next = 1'b0;
    branch_next = 1'b0;
    fin = 1'b0;
    fin_need = (state_reg == st_opcode) ? dec.need : need_reg;
    if (!fetching || take) begin
      cyc_next = cyc_reg + 3'h1;
    end
    case (state_reg)
      st_opcode, st_prefix: begin
        if (take && state_reg == st_opcode && i_fq_byte == OPC_PREFIX) begin
          state_next = st_prefix;
        end else if (take && !dec.legal) begin
          illegal_next = 1'b1;
          state_next = st_opcode;
          cyc_next = CYC_FIRST;
        end else if (take) begin
          op_next = dec.op;
          mode_next = dec.mode;
          need_next = dec.need;
          left_next = dec.nbytes;
          to_index_next = dec.to_index;
          if (dec.nbytes != 2'h0) begin
            state_next = st_operand;
          end else if (dec.mode == indexed_no_offset_mode) begin
            addr_next = hx_reg;
            req_next = 1'b1;
            state_next = st_read;
          end else begin
            // register shift finishes in its own opcode cycle
            if (tgt_x) begin
              hx_next[7:0] = alu_res;
            end else begin
              acc_next = alu_res;
            end
            ccr_next = alu_ccr;
            fin = 1'b1;
          end
        end
      end
      st_operand: begin
        if (take && left_reg == 2'h2) begin
          hi_next = i_fq_byte;
          left_next = 2'h1;
        end else if (take) begin
          case (mode_reg)
            immediate_mode, relative_mode: begin
              case (op_reg)
                stack_ptr_imm_add_op: sp_next = sp_reg + sext8(i_fq_byte);
                index_pair_imm_add_op: hx_next = hx_reg + sext8(i_fq_byte);
                branch_carry_clear_op: begin
                  if (!ccr_reg[CCR_C]) begin
                    pc_next = pc_reg + 16'h0001 + sext8(i_fq_byte);
                    branch_next = 1'b1;
                  end
                end
                default: begin
                  acc_next = alu_res;
                  ccr_next = alu_ccr;
                end
              endcase
              fin = 1'b1;
            end
            default: begin
              addr_next = ea;
              req_next = 1'b1;
              state_next = st_read;
            end
          endcase
        end
      end
      st_read: begin
        ccr_next = alu_ccr;
        if (is_shift) begin
          // read-modify-write: result goes back to the same location
          wdata_next = alu_res;
          req_next = 1'b1;
          we_next = 1'b1;
          state_next = st_write;
        end else begin
          acc_next = alu_res;
          fin = 1'b1;
        end
      end
      st_write: fin = 1'b1;
      st_pad: fin = 1'b1;
      default: state_next = st_opcode;
    endcase
    done_now = fin && (cyc_reg == fin_need);
    if (done_now) begin
      state_next = st_opcode;
      cyc_next = CYC_FIRST;
      done_next = 1'b1;
    end else if (fin) begin
      state_next = st_pad;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= st_opcode;
      op_reg <= none_op;
      mode_reg <= inherent_mode;
      need_reg <= CYC_FIRST;
      cyc_reg <= CYC_FIRST;
      left_reg <= 2'h0;
      to_index_reg <= 1'b0;
      hi_reg <= 8'h00;
      acc_reg <= ACC_RESET;
      ccr_reg <= CCR_RESET;
      wdata_reg <= 8'h00;
      hx_reg <= HX_RESET;
      sp_reg <= SP_RESET;
      pc_reg <= PC_RESET;
      addr_reg <= 16'h0000;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      branch_reg <= 1'b0;
    end else if (i_ce) begin
      state_reg <= state_next;
      op_reg <= op_next;
      mode_reg <= mode_next;
      need_reg <= need_next;
      cyc_reg <= cyc_next;
      left_reg <= left_next;
      to_index_reg <= to_index_next;
      hi_reg <= hi_next;
      acc_reg <= acc_next;
      ccr_reg <= ccr_next;
      wdata_reg <= wdata_next;
      hx_reg <= hx_next;
      sp_reg <= sp_next;
      pc_reg <= pc_next;
      addr_reg <= addr_next;
      req_reg <= req_next;
      we_reg <= we_next;
      done_reg <= done_next;
      illegal_reg <= illegal_next;
      branch_reg <= branch_next;
    end
  end

  assign o_mem_req = req_reg;
  assign o_mem_we = we_reg;
  assign o_mem_addr = addr_reg;
  assign o_mem_wdata = wdata_reg;
  assign o_acc = acc_reg;
  assign o_hx = hx_reg;
  assign o_sp = sp_reg;
  assign o_pc = pc_reg;
  assign o_ccr = ccr_reg;
  assign o_done = done_reg;
  assign o_illegal = illegal_reg;
  assign o_branch = branch_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // independent length count, so the padding counter is checked, not echoed
  logic [2:0] len_q, last_len_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      len_q <= 3'h0;
      last_len_q <= 3'h0;
    end else if (i_ce && (!fetching || take)) begin
      len_q <= (done_now || illegal_next) ? 3'h0 : len_q + 3'h1;
      if (done_now) begin
        last_len_q <= len_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  adc_sum_a: assert property (alu_op == add_carry_op |->
    alu_res == 8'(alu_a + alu_m + {7'h00, ccr_reg[CCR_C]}) && alu_ccr[CCR_I] == ccr_reg[CCR_I])
    else $error("add with carry result wrong");
  add_sum_a: assert property (alu_op == add_op |->
    alu_res == 8'(alu_a + alu_m) && alu_ccr[CCR_C] == ((9'(alu_a) + 9'(alu_m)) > 9'h0FF))
    else $error("add result or carry wrong");
  and_flags_a: assert property (alu_op == and_op |->
    !alu_ccr[CCR_V] && alu_ccr[CCR_H] == ccr_reg[CCR_H] && alu_ccr[CCR_C] == ccr_reg[CCR_C])
    else $error("and flags wrong");
  nz_flags_a: assert property (alu_op inside {add_carry_op, add_op, and_op} |->
    alu_ccr[CCR_N] == alu_res[7] && alu_ccr[CCR_Z] == (alu_res == 8'h00))
    else $error("negative or zero flag wrong");
  shift_bits_a: assert property (is_shift |->
    (alu_op == arith_right_shift_op) ?
      (alu_res[7] == alu_a[7] && alu_ccr[CCR_C] == alu_a[0]) :
      (alu_res[0] == 1'b0 && alu_ccr[CCR_C] == alu_a[7]))
    else $error("shift bit movement wrong");
  stack_len_a: assert property (o_done && op_reg == add_carry_op &&
    mode_reg == stack_off16_mode |-> last_len_q == 3'h5)
    else $error("stack off16 arithmetic length wrong");
  // op_reg, not the decoder: in the done cycle the decoder already sees the next byte
  shift_len_a: assert property (o_done && mode_reg == stack_off8_mode &&
    op_reg inside {arith_left_shift_op, arith_right_shift_op} |-> last_len_q == 3'h6)
    else $error("stack shift length wrong");
  flags_hold_a: assert property (i_ce && state_reg != st_opcode &&
    op_reg inside {stack_ptr_imm_add_op, index_pair_imm_add_op, branch_carry_clear_op}
    |=> $stable(ccr_reg))
    else $error("flags changed by add-immediate or branch");
  sp_add_a: assert property (i_ce && take && state_reg == st_operand &&
    op_reg == stack_ptr_imm_add_op |=> sp_reg == $past(sp_reg) + sext8($past(i_fq_byte)))
    else $error("stack pointer add wrong");
  // a low enable holds the pulse, so only an enabled cycle promises done next
  branch_cc_a: assert property (o_branch && i_ce |-> !ccr_reg[CCR_C] ##1 o_done)
    else $error("branch taken with carry set or not finished");
  direct_addr_a: assert property (o_mem_req && mode_reg == direct_mode |->
    o_mem_addr[15:8] == DIRECT_PAGE)
    else $error("direct page address high byte not zero");

  cover property (o_done && op_reg == add_carry_op && mode_reg == stack_off16_mode);
  cover property (o_branch);
  cover property (o_done && op_reg == arith_right_shift_op && mode_reg == inherent_mode);
  cover property (o_done && op_reg == index_pair_imm_add_op);

endmodule

// [testbench/cas_mem_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// zero-wait memory on the far side of the core
// ----------------------------------------------------------------
module cas_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  // an idle bus shows the inverse of the last byte, so stale data never passes
  assign o_rdata = (i_req && !i_we) ? mem[i_addr] : ~last_q;
  // a write lands at the edge that ends its bus cycle
  always @(posedge i_ref_clk) begin
    if (i_req) begin
      last_q <= i_we ? i_wdata : mem[i_addr];
      if (i_we) mem[i_addr] <= i_wdata;
    end
  end
endmodule

// [testbench/cas_core_tb_top.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench: instruction rows, then hand cases
// ----------------------------------------------------------------
module cas_core_tb_top;
  import cas_pkg::*;
  typedef struct packed {logic [23:0] prog; logic [1:0] n; logic [2:0] cyc;
    logic [7:0] acc; logic [7:0] condition_code_reg;} cas_row_t;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_fq_valid = 1'b0, o_fq_ready;
  logic o_mem_req, o_mem_we, o_done, o_illegal, o_branch;
  logic [7:0] i_fq_byte = 8'h00, o_mem_wdata, i_mem_rdata, o_acc, o_ccr;
  logic [15:0] o_mem_addr, o_hx, o_sp, o_pc;
  int err_total = 0, checks = 0, cyc = 0, br_cnt = 0;
  logic [7:0] bad [3] = '{8'h71, 8'h61, 8'h00};
  // state carries from row to row; the memory operands of the direct and extended rows sit in memory
  cas_row_t rows [15] = '{
    '{24'hAB7F00, 2'h2, 3'h2, 8'h7F, 8'h00}, '{24'hAB0100, 2'h2, 3'h2, 8'h80, 8'h94},
    '{24'hA4C000, 2'h2, 3'h2, 8'h80, 8'h14}, '{24'hA98000, 2'h2, 3'h2, 8'h00, 8'h83},
    '{24'hA90000, 2'h2, 3'h2, 8'h01, 8'h00}, '{24'hCB1234, 2'h3, 3'h4, 8'h80, 8'h94},
    '{24'h480000, 2'h1, 3'h1, 8'h00, 8'h93}, '{24'hA7FE00, 2'h2, 3'h2, 8'h00, 8'h93},
    '{24'hAF1000, 2'h2, 3'h2, 8'h00, 8'h93}, '{24'hEB3000, 2'h2, 3'h3, 8'h81, 8'h04},
    '{24'h470000, 2'h1, 3'h1, 8'hC0, 8'h05}, '{24'h240500, 2'h2, 3'h3, 8'hC0, 8'h05},
    '{24'h384000, 2'h2, 3'h5, 8'hC0, 8'h81}, '{24'h9EEB01, 2'h3, 3'h4, 8'hC1, 8'h04},
    '{24'h241000, 2'h2, 3'h3, 8'hC1, 8'h04}};
  cas_core cas_core_i (.i_ref_clk, .i_rst, .i_ce, .i_fq_valid, .i_fq_byte, .o_fq_ready,
    .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_rdata, .o_acc, .o_hx,
    .o_sp, .o_pc, .o_ccr, .o_done, .o_illegal, .o_branch);
  cas_mem_model cas_mem_model_i (.i_ref_clk, .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  // clock at 4 ns
  initial forever #2 i_ref_clk = ~i_ref_clk;
  // cycle count, taken-branch count and hang guard
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (o_branch === 1'b1) br_cnt <= br_cnt + 1;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one byte stays offered until an edge sees ready high
  task automatic send(input logic [7:0] b);
    i_fq_valid <= 1'b1;
    i_fq_byte <= b;
    #1;
    while (o_fq_ready !== 1'b1) begin
      @(posedge i_ref_clk);
      #1;
    end
    @(posedge i_ref_clk);
  endtask
  task automatic run(input cas_row_t r);
    int t0;
    t0 = 0;
    for (int i = 0; i < r.n; i++) begin
      send(r.prog[23-8*i -: 8]);
      if (i == 0) t0 = cyc;
    end
    i_fq_valid <= 1'b0;
    #1;
    while (o_done !== 1'b1) begin
      @(posedge i_ref_clk);
      #1;
    end
    check("cycles", 16'(cyc - t0), {13'h0, r.cyc});
    check("acc", {8'h00, o_acc}, {8'h00, r.acc});
    check("ccr", {8'h00, o_ccr}, {8'h00, r.condition_code_reg});
    @(posedge i_ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    cas_mem_model_i.mem[16'h1234] = 8'h7F;
    cas_mem_model_i.mem[16'h0040] = 8'h81;
    cas_mem_model_i.mem[16'h00FE] = 8'h01;
    cas_mem_model_i.mem[16'h0100] = 8'h01;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    check("sp reset", o_sp, SP_RESET);
    check("pc reset", o_pc, PC_RESET);
    @(posedge i_ref_clk);
    foreach (rows[k]) run(rows[k]);
    check("written byte", {8'h00, cas_mem_model_i.mem[16'h0040]}, 16'h0002);
    check("sp", o_sp, 16'h00FD);
    check("hx", o_hx, 16'h0010);
    check("pc", o_pc, 16'h002E);
    check("branches", 16'(br_cnt), 16'h0001);
    // post-increment indexed codes and an unmapped code are refused
    foreach (bad[k]) begin
      send(bad[k]);
      i_fq_valid <= 1'b0;
      #1;
      check("illegal", {15'h0, o_illegal}, 16'h0001);
      @(posedge i_ref_clk);
    end
    // second reset in mid-instruction: registers and sequencer start clean
    send(8'hCB);
    i_fq_valid <= 1'b0;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    check("acc reset", {8'h00, o_acc}, {8'h00, ACC_RESET});
    check("ccr reset", {8'h00, o_ccr}, {8'h00, CCR_RESET});
    check("sp reset 2", o_sp, SP_RESET);
    check("pc reset 2", o_pc, PC_RESET);
    @(posedge i_ref_clk);
    run(cas_row_t'{24'hAB0500, 2'h2, 3'h2, 8'h05, 8'h00});
    // enable low freezes everything, even with a byte on offer
    i_ce <= 1'b0;
    i_fq_valid <= 1'b1;
    i_fq_byte <= 8'h48;
    repeat (3) @(posedge i_ref_clk);
    #1;
    check("frozen pc", o_pc, 16'h0002);
    check("frozen acc", {8'h00, o_acc}, 16'h0005);
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    run(cas_row_t'{24'h480000, 2'h1, 3'h1, 8'h0A, 8'h00});
    // stack-offset shift: sp 00FF plus 01 reaches 0100
    run(cas_row_t'{24'h9E6801, 2'h3, 3'h6, 8'h0A, 8'h00});
    check("stack byte", {8'h00, cas_mem_model_i.mem[16'h0100]}, 16'h0002);
    tally_and_finish();
  end
endmodule
